// File: hdl/logic_cell_defs.svh
/*
 Constants of the programmable logic cell: field widths, counts and reset values.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef LOGIC_CELL_DEFS_SVH
`define LOGIC_CELL_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define LC_TABLE_INPUTS    3
`define LC_TABLE_ROWS      8
`define LC_ORIGIN_BITS     5
`define LC_INDEX_BITS      2
`define LC_ROW_BITS        3
`define LC_LINE_COUNT      4
`define LC_USER_COUNT      4
`define LC_COUNTER_COUNT   2
`define LC_CELL_COUNT      2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LC_TABLE_RESET     8'h00
`define LC_OUTPUT_RESET    1'b0

`endif

// File: hdl/logic_cell_pkg.sv
/*
 Types of the programmable logic cell: origins, qualifiers, table targets and
 the configuration strobe bundle.
 Assumes logic_cell_defs.svh is on the include path.
*/
`include "logic_cell_defs.svh"

package logic_cell_pkg;

   // -------------------------------------------------------------------------
   // Enumerations
   // -------------------------------------------------------------------------
   typedef enum logic [`LC_ORIGIN_BITS-1:0] {
      ORIGIN_ZERO, ORIGIN_LINE0, ORIGIN_LINE1, ORIGIN_LINE2, ORIGIN_LINE3,
      ORIGIN_USER0, ORIGIN_USER1, ORIGIN_USER2, ORIGIN_USER3,
      ORIGIN_CNT0_START, ORIGIN_CNT1_START, ORIGIN_CNT0_END, ORIGIN_CNT1_END,
      ORIGIN_CELL0, ORIGIN_CELL1, ORIGIN_SHUTTER_OPEN, ORIGIN_SHUTTER_CLOSE,
      ORIGIN_FRAME_TRIGGER_PENDING, ORIGIN_CAPTURE_RUNNING
   } table_input_origin_e;

   typedef enum logic [2:0] {
      ACTIVE_LOW_LEVEL, ACTIVE_HIGH_LEVEL, FALL_TRANSITION, RISE_TRANSITION,
      EITHER_TRANSITION
   } table_input_qualifier_e;

   typedef enum logic {
      TARGET_VALUE, TARGET_ENABLE
   } table_target_select_e;

   // -------------------------------------------------------------------------
   // Configuration strobes that travel together
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic                         inputWrite;
      logic [`LC_INDEX_BITS-1:0]    tableInputIndex;
      table_input_origin_e          tableInputOrigin;
      table_input_qualifier_e       tableInputQualifier;
      table_target_select_e         tableTargetSelect;
      logic                         rowWrite;
      logic [`LC_ROW_BITS-1:0]      truthRowNumber;
      logic                         truthRowBit;
      logic                         wordWrite;
      logic [`LC_TABLE_ROWS-1:0]    truthTableWord;
   } cell_config_s;

   // Internal event sources presented to every cell input.
   typedef struct packed {
      logic [`LC_LINE_COUNT-1:0]    lines;
      logic [`LC_USER_COUNT-1:0]    userOutputs;
      logic [`LC_COUNTER_COUNT-1:0] counterStart;
      logic [`LC_COUNTER_COUNT-1:0] counterEnd;
      logic [`LC_CELL_COUNT-1:0]    cellOutputs;
      logic                         shutterOpenEvent;
      logic                         shutterCloseEvent;
      logic                         frameTriggerPending;
      logic                         captureRunning;
   } cell_sources_s;

endpackage

// File: hdl/input_qualifier.sv
/*
 One qualified table input: picks a source and turns a level or edge into a
 true input. Assumes sources are synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module input_qualifier
   import logic_cell_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   rst_b,
   input  wire logic_cell_pkg::cell_sources_s        sources,
   input  wire logic_cell_pkg::table_input_origin_e  origin,
   input  wire logic_cell_pkg::table_input_qualifier_e qualifier,
   output logic                        qualified
);
   logic picked;
   logic pickedLast;

   // ----------------------------------------------------------------------
   // Source selection
   // ----------------------------------------------------------------------
   // Unused origin codes read as zero, like the zero origin.
   always_comb
   begin
      case (origin)
         ORIGIN_ZERO:                  picked = 1'b0;
         ORIGIN_LINE0:                 picked = sources.lines[0];
         ORIGIN_LINE1:                 picked = sources.lines[1];
         ORIGIN_LINE2:                 picked = sources.lines[2];
         ORIGIN_LINE3:                 picked = sources.lines[3];
         ORIGIN_USER0:                 picked = sources.userOutputs[0];
         ORIGIN_USER1:                 picked = sources.userOutputs[1];
         ORIGIN_USER2:                 picked = sources.userOutputs[2];
         ORIGIN_USER3:                 picked = sources.userOutputs[3];
         ORIGIN_CNT0_START:            picked = sources.counterStart[0];
         ORIGIN_CNT1_START:            picked = sources.counterStart[1];
         ORIGIN_CNT0_END:              picked = sources.counterEnd[0];
         ORIGIN_CNT1_END:              picked = sources.counterEnd[1];
         ORIGIN_CELL0:                 picked = sources.cellOutputs[0];
         ORIGIN_CELL1:                 picked = sources.cellOutputs[1];
         ORIGIN_SHUTTER_OPEN:          picked = sources.shutterOpenEvent;
         ORIGIN_SHUTTER_CLOSE:         picked = sources.shutterCloseEvent;
         ORIGIN_FRAME_TRIGGER_PENDING: picked = sources.frameTriggerPending;
         ORIGIN_CAPTURE_RUNNING:       picked = sources.captureRunning;
         default:                      picked = 1'b0;
      endcase
   end

   // Previous sample for edge detection; reset clears it, so a source high after reset shows a rise at once.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         pickedLast <= 1'b0;
      else
         pickedLast <= picked;
   end

   // ----------------------------------------------------------------------
   // Qualification
   // ----------------------------------------------------------------------
   // An edge gives a one-cycle true pulse in the cycle the new level shows.
   always_comb
   begin
      case (qualifier)
         ACTIVE_LOW_LEVEL:  qualified = ~picked;
         ACTIVE_HIGH_LEVEL: qualified = picked;
         FALL_TRANSITION:   qualified = pickedLast & ~picked;
         RISE_TRANSITION:   qualified = ~pickedLast & picked;
         EITHER_TRANSITION: qualified = pickedLast ^ picked;
         default:           qualified = 1'b0;
      endcase
   end
endmodule

`default_nettype wire

// File: hdl/logic_cell.sv
/*
 Programmable logic cell: two three-input lookup tables sharing qualified
 inputs, feeding an output flip-flop through its data and enable.
 Assumes all sources and configuration strobes are synchronous to sys_clk.
*/
// How it works
// - Value table drives flip-flop data; enable table drives flip-flop enable.
// - Each table has three single-bit inputs and eight truth bits.
// - Both tables share one set of input source and qualifier settings.
// - Each input picks its source; a target select picks the table configured.
// - A per-input qualifier decides which level or edge counts as true.
// - Truth bits written one row at a time or as a whole word.
// - Word bit n is row n; input 2 is the row's top bit.
// - Output holds while enable is false, loads value while enable true.
// - Enable table all ones makes the output follow the value table.
// - Sources are zero, lines, user outputs, counter events, cells, shutter, frame trigger, capture.
// - Qualifiers are low level, high level, fall, rise, either edge.
`timescale 1ns/100ps
`default_nettype none
`include "logic_cell_defs.svh"

module logic_cell
   import logic_cell_pkg::*;
#(
   parameter int INPUTS = `LC_TABLE_INPUTS
)
(
   input  wire logic                          sys_clk,
   input  wire logic                          rst_b,
   input  wire logic_cell_pkg::cell_config_s  cfg,
   input  wire logic_cell_pkg::cell_sources_s sources,
   output logic [`LC_TABLE_ROWS-1:0]          valueTable,
   output logic [`LC_TABLE_ROWS-1:0]          enableTable,
   output logic [INPUTS-1:0]                  tableInputs,
   output logic                               cellOutput
);
   import logic_cell_pkg::*;

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   // The row width and table depth are fixed at three inputs.
   if (INPUTS != `LC_TABLE_INPUTS)
      $error("logic_cell supports exactly three table inputs");
   // The truth word must hold one bit for every combination of the inputs.
   if (`LC_TABLE_ROWS != (1 << INPUTS))
      $error("logic_cell truth word width does not match the row count");

   table_input_origin_e    origins    [INPUTS];
   table_input_qualifier_e qualifiers [INPUTS];
   logic                   valueBit;
   logic                   enableBit;

   // Row lookup shared by both tables.
   function automatic logic table_row(input logic [`LC_TABLE_ROWS-1:0] tbl,
                                      input logic [INPUTS-1:0] row);
      table_row = tbl[row];
   endfunction

   // ----------------------------------------------------------------------
   // Shared input settings
   // ----------------------------------------------------------------------
   // One bank of settings, whichever table is targeted, so both see them.
   generate
      for (genvar i = 0; i < INPUTS; i++)
      begin : g_input
         always_ff @(posedge sys_clk)
         begin
            if (!rst_b)
            begin
               origins[i]    <= ORIGIN_ZERO;
               qualifiers[i] <= ACTIVE_HIGH_LEVEL;
            end
            else if (cfg.inputWrite && cfg.tableInputIndex == `LC_INDEX_BITS'(i))
            begin
               origins[i]    <= cfg.tableInputOrigin;
               qualifiers[i] <= cfg.tableInputQualifier;
            end
         end

         input_qualifier u_qual
         (
            .sys_clk   (sys_clk),
            .rst_b     (rst_b),
            .sources   (sources),
            .origin    (origins[i]),
            .qualifier (qualifiers[i]),
            .qualified (tableInputs[i])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Truth tables
   // ----------------------------------------------------------------------
   // A word write wins over a row write in the same cycle, being the later,
   // broader command; software should not issue both at once.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         valueTable <= `LC_TABLE_RESET;
      else if (cfg.tableTargetSelect == TARGET_VALUE && cfg.wordWrite)
         valueTable <= cfg.truthTableWord;
      else if (cfg.tableTargetSelect == TARGET_VALUE && cfg.rowWrite)
         valueTable[cfg.truthRowNumber] <= cfg.truthRowBit;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         enableTable <= `LC_TABLE_RESET;
      else if (cfg.tableTargetSelect == TARGET_ENABLE && cfg.wordWrite)
         enableTable <= cfg.truthTableWord;
      else if (cfg.tableTargetSelect == TARGET_ENABLE && cfg.rowWrite)
         enableTable[cfg.truthRowNumber] <= cfg.truthRowBit;
   end

   // Input 2 is the most significant row bit.
   always_comb
   begin
      valueBit  = table_row(valueTable, tableInputs);
      enableBit = table_row(enableTable, tableInputs);
   end

   // ----------------------------------------------------------------------
   // Output flip-flop
   // ----------------------------------------------------------------------
   // The output lags the tables by one clock; all-ones enable passes through.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         cellOutput <= `LC_OUTPUT_RESET;
      else if (enableBit)
         cellOutput <= valueBit;
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // Output flip-flop: hold on a false enable row, load on a true one.
   chk_hold_when_off: assert property (!enableBit |=> $stable(cellOutput))
      else $error("cell output changed while enable table false");
   chk_load_when_on: assert property (enableBit |=> cellOutput == $past(valueBit))
      else $error("cell output did not load value table bit");
   chk_bypass_follow: assert property
      ((enableTable == 8'hFF) ##1 (enableTable == 8'hFF) |-> cellOutput == $past(valueBit))
      else $error("all-ones enable table did not pass value through");

   // Reset clears the output and both tables; this one runs through reset,
   // since the default disable would otherwise hide the very cycle it guards.
   chk_reset_clears: assert property
      (disable iff (1'b0) !rst_b |=> cellOutput == `LC_OUTPUT_RESET
       && valueTable == `LC_TABLE_RESET && enableTable == `LC_TABLE_RESET)
      else $error("reset did not clear output and tables");

   // Table writes reach only the targeted table, as a whole word or one row.
   chk_word_write: assert property
      (cfg.wordWrite && cfg.tableTargetSelect == TARGET_VALUE
       |=> valueTable == $past(cfg.truthTableWord))
      else $error("value table word write not stored");
   chk_enable_word: assert property
      (cfg.wordWrite && cfg.tableTargetSelect == TARGET_ENABLE
       |=> enableTable == $past(cfg.truthTableWord))
      else $error("enable table word write not stored");
   chk_row_write: assert property
      (cfg.rowWrite && !cfg.wordWrite && cfg.tableTargetSelect == TARGET_ENABLE
       |=> enableTable[$past(cfg.truthRowNumber)] == $past(cfg.truthRowBit))
      else $error("enable table row write not stored");
   chk_value_row: assert property
      (cfg.rowWrite && !cfg.wordWrite && cfg.tableTargetSelect == TARGET_VALUE
       |=> valueTable[$past(cfg.truthRowNumber)] == $past(cfg.truthRowBit))
      else $error("value table row write not stored");
   chk_other_untouched: assert property
      (cfg.tableTargetSelect == TARGET_ENABLE |=> $stable(valueTable))
      else $error("value table changed while enable targeted");
   chk_enable_untouched: assert property
      (cfg.tableTargetSelect == TARGET_VALUE |=> $stable(enableTable))
      else $error("enable table changed while value targeted");

   // The AND of inputs 2 and 1 only comes through if input 2 is the top row bit.
   chk_row_order: assert property
      (enableTable == 8'hFF && valueTable == 8'hC0 && tableInputs == 3'b110 |=> cellOutput)
      else $error("input 2 is not the top row bit");

   // Input settings are shared by both tables, and index three selects nothing.
   chk_shared_inputs: assert property
      (cfg.inputWrite && cfg.tableInputIndex == 2'd1
       |=> origins[1] == $past(cfg.tableInputOrigin))
      else $error("input setting not stored regardless of target");
   chk_index_ignored: assert property
      (cfg.inputWrite && cfg.tableInputIndex == 2'd3
       |=> $stable(origins[0]) && $stable(origins[1]) && $stable(origins[2]))
      else $error("write to the fourth input index changed a setting");

   // Qualification: a settled zero source is true only under the low level,
   // and a rise or fall qualifier is true for one cycle unless its settings move.
   chk_low_inverts: assert property
      (origins[0] == ORIGIN_ZERO && qualifiers[0] == ACTIVE_LOW_LEVEL |-> tableInputs[0])
      else $error("active low level of a zero source was not true");
   chk_zero_no_edge: assert property
      (origins[0] == ORIGIN_ZERO && $stable(origins[0]) && qualifiers[0] != ACTIVE_LOW_LEVEL
       |-> !tableInputs[0])
      else $error("settled zero source counted as true");
   chk_rise_pulse: assert property
      (qualifiers[0] == RISE_TRANSITION && $stable(qualifiers[0]) && $stable(origins[0])
       && tableInputs[0] |=> !tableInputs[0] || !$stable(qualifiers[0])
       || !$stable(origins[0]))
      else $error("rising edge qualifier held true past one cycle");
   chk_fall_pulse: assert property
      (qualifiers[2] == FALL_TRANSITION && $stable(qualifiers[2]) && $stable(origins[2])
       && tableInputs[2] |=> !tableInputs[2] || !$stable(qualifiers[2])
       || !$stable(origins[2]))
      else $error("falling edge qualifier held true past one cycle");

   // Main scenarios that a run should reach at least once.
   cov_latch_hold: cover property (enableBit ##1 !enableBit [*3]);
   cov_bypass: cover property (enableTable == 8'hFF && valueBit ##1 cellOutput);
   cov_either_edge: cover property (qualifiers[0] == EITHER_TRANSITION && tableInputs[0]);
   cov_and_table: cover property (valueTable == 8'hC0 && tableInputs == 3'b110);
   cov_word_and_row: cover property (cfg.wordWrite && cfg.rowWrite);
endmodule

`default_nettype wire

// File: testbench/source_model.sv
/*
 Far-side model of the internal event sources seen by one logic cell.
 Assumes the bench hands it the next source levels and shares sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module source_model
   import logic_cell_pkg::*;
(
   input  wire logic                          sys_clk,
   input  wire logic_cell_pkg::cell_sources_s stimulus,
   input  wire logic                          cellOutput,
   output logic_cell_pkg::cell_sources_s      sources
);
   // Real event logic is synchronous, so levels move only on the clock.
   // Cell 0 is fed back so that a cell can watch its own output.
   always_ff @(posedge sys_clk)
   begin
      sources <= stimulus;
      sources.cellOutputs[0] <= cellOutput;
   end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
/*
 Self-checking bench for logic_cell: a cycle reference model compared every cycle.
 Assumes the logic_cell_pkg package and source_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import logic_cell_pkg::*;

   logic          sys_clk, rst_b, cellOutput, expOut, randSrc, randCfg;
   cell_config_s  cfg, scratch;
   cell_sources_s nextSrc, sources;
   logic [7:0]    valueTable, enableTable, expVal, expEn;
   logic [2:0]    tableInputs, expIn, hist;
   logic [4:0]    org [3];
   logic [2:0]    qual [3];
   int            miscompares, n_tests, cycles;
   int            seed = 32'hcf67_f2d7;

   logic_cell dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .sources(sources),
      .valueTable(valueTable), .enableTable(enableTable), .tableInputs(tableInputs),
      .cellOutput(cellOutput));
   source_model far (.sys_clk(sys_clk), .stimulus(nextSrc), .cellOutput(cellOutput),
      .sources(sources));

   always #5 sys_clk = ~sys_clk;

   // ---------------------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------------------
   // Codes past the last origin read as zero, like the zero origin itself.
   function automatic logic pick(cell_sources_s s, logic [4:0] o);
      logic [18:0] v;
      v = {s.captureRunning, s.frameTriggerPending, s.shutterCloseEvent, s.shutterOpenEvent,
           s.cellOutputs, s.counterEnd, s.counterStart, s.userOutputs, s.lines, 1'b0};
      return (o < 5'd19) ? v[o] : 1'b0;
   endfunction

   function automatic logic qualify(logic cur, logic prev, logic [2:0] q);
      case (q)
         ACTIVE_LOW_LEVEL:  return !cur;
         ACTIVE_HIGH_LEVEL: return cur;
         FALL_TRANSITION:   return prev & !cur;
         RISE_TRANSITION:   return !prev & cur;
         EITHER_TRANSITION: return prev ^ cur;
         default:           return 1'b0;
      endcase
   endfunction

   // Row index is {input2, input1, input0}, so it indexes the table word directly.
   always_comb
   begin
      for (int i = 0; i < 3; i++)
         expIn[i] = qualify(pick(sources, org[i]), hist[i], qual[i]);
   end

   always @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         expVal <= 8'h00;
         expEn <= 8'h00;
         expOut <= 1'b0;
         hist <= 3'b000;
         org <= '{3{5'h00}};
         qual <= '{3{3'h1}};
      end
      else
      begin
         if (expEn[expIn]) expOut <= expVal[expIn];
         // Edge history follows the selected signal, so a source switch may pulse once.
         for (int i = 0; i < 3; i++) hist[i] <= pick(sources, org[i]);
         if (cfg.inputWrite && cfg.tableInputIndex < 2'd3)
         begin
            org[cfg.tableInputIndex] <= cfg.tableInputOrigin;
            qual[cfg.tableInputIndex] <= cfg.tableInputQualifier;
         end
         if (cfg.wordWrite && cfg.tableTargetSelect == TARGET_ENABLE)
            expEn <= cfg.truthTableWord;
         else if (cfg.wordWrite)
            expVal <= cfg.truthTableWord;
         else if (cfg.rowWrite && cfg.tableTargetSelect == TARGET_ENABLE)
            expEn[cfg.truthRowNumber] <= cfg.truthRowBit;
         else if (cfg.rowWrite)
            expVal[cfg.truthRowNumber] <= cfg.truthRowBit;
      end
   end

   // ---------------------------------------------------------------------------
   // Checking and drive helpers
   // ---------------------------------------------------------------------------
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Outputs are settled by the falling edge, so no race with the launch edge.
   always @(negedge sys_clk)
   begin
      if (cycles > 0)
      begin
         check(valueTable, expVal);
         check(enableTable, expEn);
         check({5'b0_0000, tableInputs}, {5'b0_0000, expIn});
         check({7'b000_0000, cellOutput}, {7'b000_0000, expOut});
      end
   end

   // The run should need about 4000 cycles; twice that means a hang.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (randSrc) nextSrc <= 18'($random(seed));
      if (randCfg) cfg <= 26'($random(seed));
      if (cycles == 8000)
      begin
         miscompares++;
         close_out();
      end
   end

   task automatic put(cell_config_s c);
      @(posedge sys_clk);
      cfg <= c;
   endtask

   task automatic tbl(logic tgt, logic isWord, int row, logic [7:0] w);
      scratch = '0;
      scratch.tableTargetSelect = table_target_select_e'(tgt);
      scratch.wordWrite = isWord;
      scratch.rowWrite = !isWord;
      scratch.truthRowNumber = 3'(row);
      scratch.truthRowBit = w[0];
      scratch.truthTableWord = w;
      put(scratch);
   endtask

   task automatic setIn(int idx, int o, int q);
      scratch = '0;
      scratch.inputWrite = 1'b1;
      scratch.tableInputIndex = 2'(idx);
      scratch.tableInputOrigin = table_input_origin_e'(5'(o));
      scratch.tableInputQualifier = table_input_qualifier_e'(3'(q));
      put(scratch);
   endtask

   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      rst_b = 1'b0;
      cfg = '0;
      nextSrc = '0;
      randSrc = 1'b0;
      randCfg = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      // AND of inputs 2 and 1 on lines, with the latch bypassed by an all-ones enable.
      for (int i = 0; i < 3; i++) setIn(i, 1 + i, 1);
      tbl(1'b0, 1'b1, 0, 8'hC0);
      tbl(1'b1, 1'b1, 0, 8'hFF);
      put('0);
      for (int p = 0; p < 8; p++)
      begin
         nextSrc.lines <= 4'(p);
         repeat (2) @(posedge sys_clk);
      end
      // All-zero enable: the output must hold while the sources churn.
      tbl(1'b1, 1'b1, 0, 8'h00);
      put('0);
      randSrc <= 1'b1;
      repeat (20) @(posedge sys_clk);
      // Word and row in one cycle, then every row alone, then the unused fourth input.
      scratch = '0;
      scratch.wordWrite = 1'b1;
      scratch.rowWrite = 1'b1;
      scratch.truthRowBit = 1'b1;
      scratch.truthTableWord = 8'h5A;
      put(scratch);
      for (int r = 0; r < 8; r++) tbl(1'b1, 1'b0, r, 8'(r));
      setIn(3, 18, 0);
      // Every origin under every qualifier, one illegal qualifier code included.
      for (int o = 0; o < 19; o++)
         for (int q = 0; q < 6; q++)
         begin
            setIn(o % 3, o, q);
            put('0);
            repeat (3) @(posedge sys_clk);
         end
      randCfg <= 1'b1;
      repeat (3000) @(posedge sys_clk);
      randCfg <= 1'b0;
      put('0);
      // Reset in mid-run with live sources: edge history must start from zero.
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (20) @(posedge sys_clk);
      close_out();
   end
endmodule

`default_nettype wire
